// ### rtl/mtseq_map.svh
// register map, field positions, reset values and timing of the trigger sequencer
`ifndef MTSEQ_MAP_SVH
`define MTSEQ_MAP_SVH

`define MTS_ADDR_W 8
`define MTS_OFS_CTRL 8'h00
`define MTS_OFS_SAMP 8'h04
`define MTS_OFS_TRIG 8'h08
`define MTS_OFS_DELAY 8'h0c
`define MTS_OFS_MCFG 8'h10
`define MTS_OFS_MODE 8'h14
`define MTS_OFS_STATUS 8'h18
`define MTS_OFS_HELD 8'h1c

`define MTS_CTRL_ARM 0
`define MTS_CTRL_DCLR 1
`define MTS_CTRL_CONF 2
`define MTS_CTRL_IFRST 3
`define MTS_CTRL_BUSTRG 4

`define MTS_TRIG_INF 31
`define MTS_DELAY_AUTO 31

`define MTS_MODE_REMOTE 0
`define MTS_MODE_IMM 1
`define MTS_MODE_FPAUTO 2
`define MTS_MODE_HOLD 3
`define MTS_MODE_BEEP 4
`define MTS_MODE_BAND_LO 8
`define MTS_MODE_W 10
`define MTS_MODE_RESET 10'h104

`define MTS_MCFG_W 14
`define MTS_MCFG_RNG_LO 4
`define MTS_MCFG_INTEGRATION_LINE_CYCLES 8
`define MTS_MCFG_FILT_LO 12

`define MTS_STAT_PEND 4
`define MTS_STAT_HOLD 5
`define MTS_STAT_REMOTE 6
`define MTS_STAT_SAMP_LO 16

`define MTS_CNT_MAX 50000
`define MTS_CNT_DEF 1
`define MTS_DLY_MAX_S 3600

`define MTS_CLK_NS 50
`define MTS_TICK_US 100
`define MTS_SETUP_US 20000
`define MTS_US_PER_S 1000000

`define MTS_AD_SHORT_US 1000
`define MTS_AD_LONG_US 1500
`define MTS_AD_RES1M_HI_US 15000
`define MTS_AD_RES1M_LO_US 10000
`define MTS_AD_RESHI_US 100000
`define MTS_AD_AC_SLOW_US 7000000
`define MTS_AD_AC_MED_US 1000000
`define MTS_AD_AC_FAST_US 600000
`define MTS_AD_ACFP_SLOW_US 1500000
`define MTS_AD_ACFP_MED_US 200000
`define MTS_AD_ACFP_FAST_US 100000
`define MTS_AD_FREQ_US 1000000
`define MTS_RES_100K 3'h3
`define MTS_RES_1M 3'h4

`define MTS_HOLD_RUN 3
`define MTS_BAND_DEF 2'h1
`define MTS_BAND_SCALE0 10000
`define MTS_BAND_SCALE1 1000
`define MTS_BAND_SCALE2 100
`define MTS_BAND_SCALE3 10

`endif

// ### rtl/mtseq_pkg.sv
// types shared by the trigger sequencer files
package mtseq_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_WAIT,
    ST_DELAY,
    ST_MEAS
  } mtseq_state_t;

  typedef enum logic [2:0] {
    FN_DCV,
    FN_DCI,
    FN_RES,
    FN_ACV,
    FN_ACI,
    FN_FREQ,
    FN_PER
  } mtseq_func_t;

  typedef enum logic [1:0] {
    FL_SLOW,
    FL_MED,
    FL_FAST
  } mtseq_filt_t;

endpackage : mtseq_pkg

// ### rtl/mtseq_hold.sv
// reading-hold stability detector
`timescale 1ns/100ps
`default_nettype none
`include "mtseq_map.svh"

module mtseq_hold #(
  parameter int RD_W = 24
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic beep_en,
  input wire logic [1:0] band,
  input wire logic reading_valid,
  input wire logic [RD_W-1:0] reading,
  output logic [RD_W-1:0] held,
  output logic held_valid,
  output logic beep
);

  typedef struct packed {
    logic [RD_W-1:0] ref_v;
    logic [1:0] run;
    logic [RD_W-1:0] held;
    logic valid;
    logic beep;
  } mtseq_hold_t;

  mtseq_hold_t q, d;

  function automatic logic in_band(input logic [RD_W-1:0] a, input logic [RD_W-1:0] r,
                                   input logic [1:0] b);
    logic [RD_W-1:0] diff;
    logic [RD_W+13:0] lhs;
    diff = (a > r) ? a - r : r - a;
    unique case (b)
      2'h0: lhs = (RD_W+14)'(diff) * (RD_W+14)'(`MTS_BAND_SCALE0);
      2'h1: lhs = (RD_W+14)'(diff) * (RD_W+14)'(`MTS_BAND_SCALE1);
      2'h2: lhs = (RD_W+14)'(diff) * (RD_W+14)'(`MTS_BAND_SCALE2);
      2'h3: lhs = (RD_W+14)'(diff) * (RD_W+14)'(`MTS_BAND_SCALE3);
    endcase
    return lhs <= (RD_W+14)'(r);
  endfunction : in_band

  always_comb begin
    d = q;
    d.beep = 1'b0;
    if (!enable) begin
      d.run = 2'h0;
    end else if (reading_valid) begin
      if (q.run == 2'h0 || !in_band(reading, q.ref_v, band)) begin
        d.ref_v = reading;
        d.run = 2'h1;
      end else if (q.run == 2'(`MTS_HOLD_RUN - 1)) begin
        d.held = reading;
        d.valid = 1'b1;
        d.beep = beep_en;
        d.run = 2'h0;
      end else begin
        d.run = q.run + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign held = q.held;
  assign held_valid = q.valid;
  assign beep = q.beep;

  hold_latch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(q.valid) |-> $past(enable) && $past(reading_valid) &&
    $past(q.run) == 2'(`MTS_HOLD_RUN - 1))
    else $error("hold latched without three in-band readings");

endmodule : mtseq_hold
`default_nettype wire

// ### rtl/mtseq_top.sv
// trigger sequencer with apb registers, delay timer and reading hold
`timescale 1ns/100ps
`default_nettype none
`include "mtseq_map.svh"

module mtseq_top #(
  parameter int TICK_CYCLES = `MTS_TICK_US * 1000 / `MTS_CLK_NS,
  parameter int SETUP_TICKS = (`MTS_SETUP_US + `MTS_TICK_US - 1) / `MTS_TICK_US,
  parameter int CNT_W = 16,
  parameter int DLY_W = 26,
  parameter int RD_W = 24
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [`MTS_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_trig_n,
  input wire logic meas_done,
  input wire logic reading_valid,
  input wire logic [RD_W-1:0] reading,
  output logic meas_start,
  output logic measurement_done_output_n,
  output logic wait_trig,
  output logic beep
);

  localparam int PRE_W = $clog2(TICK_CYCLES);
  localparam int DLY_MAX = `MTS_DLY_MAX_S * (`MTS_US_PER_S / `MTS_TICK_US);

  generate
    if (TICK_CYCLES < 2 || SETUP_TICKS < 1 || CNT_W < 16 || CNT_W > 30 || DLY_W > 30 ||
        (DLY_MAX >> DLY_W) != 0 || RD_W < 2 || RD_W > 32) begin : g_bad_cfg
      $error("mtseq_top parameters out of range");
    end
  endgenerate

  typedef struct packed {
    mtseq_pkg::mtseq_state_t st;
    logic [PRE_W-1:0] pre;
    logic [DLY_W-1:0] ticks;
    logic [CNT_W-1:0] samp_done;
    logic [CNT_W-1:0] trig_done;
    logic [CNT_W-1:0] samp_cnt;
    logic [CNT_W-1:0] trig_cnt;
    logic trig_inf;
    logic dly_auto;
    logic [DLY_W-1:0] dly;
    logic [`MTS_MCFG_W-1:0] mcfg;
    logic [`MTS_MODE_W-1:0] mode;
    logic ext_prev;
    logic pend;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic start;
    logic done_n;
    logic wait_trig;
  } mtseq_regs_t;

  localparam mtseq_regs_t RESET_V = '{
    st: mtseq_pkg::ST_IDLE,
    samp_cnt: CNT_W'(`MTS_CNT_DEF),
    trig_cnt: CNT_W'(`MTS_CNT_DEF),
    dly_auto: 1'b1,
    mode: `MTS_MODE_W'(`MTS_MODE_RESET),
    ext_prev: 1'b1,
    done_n: 1'b1,
    default: '0
  };

  mtseq_regs_t q, d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [RD_W-1:0] held;
  logic held_valid;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  function automatic logic [DLY_W-1:0] us_ticks(input int us);
    return DLY_W'(us / `MTS_TICK_US);
  endfunction : us_ticks

  function automatic logic [CNT_W-1:0] clamp_cnt(input logic [31:0] v);
    if (v == 32'h0) begin
      return CNT_W'(1);
    end
    if (v > 32'(`MTS_CNT_MAX)) begin
      return CNT_W'(`MTS_CNT_MAX);
    end
    return CNT_W'(v);
  endfunction : clamp_cnt

  function automatic logic [DLY_W-1:0] auto_delay(input logic [`MTS_MCFG_W-1:0] c,
                                                  input logic fp);
    logic [2:0] rng;
    logic integration_line_cycles;
    logic [1:0] filt;
    rng = c[`MTS_MCFG_RNG_LO +: 3];
    integration_line_cycles = c[`MTS_MCFG_INTEGRATION_LINE_CYCLES];
    filt = c[`MTS_MCFG_FILT_LO +: 2];
    unique case (c[2:0])
      mtseq_pkg::FN_DCV, mtseq_pkg::FN_DCI:
        return integration_line_cycles ? us_ticks(`MTS_AD_LONG_US) : us_ticks(`MTS_AD_SHORT_US);
      mtseq_pkg::FN_RES: begin
        if (rng <= `MTS_RES_100K) begin
          return integration_line_cycles ? us_ticks(`MTS_AD_LONG_US) : us_ticks(`MTS_AD_SHORT_US);
        end
        if (rng == `MTS_RES_1M) begin
          return integration_line_cycles ? us_ticks(`MTS_AD_RES1M_HI_US) : us_ticks(`MTS_AD_RES1M_LO_US);
        end
        return us_ticks(`MTS_AD_RESHI_US);
      end
      mtseq_pkg::FN_ACV, mtseq_pkg::FN_ACI: begin
        if (filt == mtseq_pkg::FL_SLOW) begin
          return fp ? us_ticks(`MTS_AD_ACFP_SLOW_US) : us_ticks(`MTS_AD_AC_SLOW_US);
        end
        if (filt == mtseq_pkg::FL_MED) begin
          return fp ? us_ticks(`MTS_AD_ACFP_MED_US) : us_ticks(`MTS_AD_AC_MED_US);
        end
        return fp ? us_ticks(`MTS_AD_ACFP_FAST_US) : us_ticks(`MTS_AD_AC_FAST_US);
      end
      mtseq_pkg::FN_FREQ, mtseq_pkg::FN_PER:
        return fp ? '0 : us_ticks(`MTS_AD_FREQ_US);
      default:
        return us_ticks(`MTS_AD_LONG_US);
    endcase
  endfunction : auto_delay

  logic acc, wr, done_acc;
  logic ctrl_wr, arm_c, dclr_c, conf_c, ifrst_c, bus_c;
  logic local_c, ext_fall, trig_in, tick, more_trig, last_samp;
  logic [DLY_W-1:0] eff_dly;
  logic [31:0] status;

  always_comb begin
    acc = psel & penable & ~q.pready;
    done_acc = psel & penable & q.pready;
    wr = done_acc & pwrite;
    ctrl_wr = wr && paddr == `MTS_OFS_CTRL;
    arm_c = ctrl_wr & pwdata[`MTS_CTRL_ARM];
    dclr_c = ctrl_wr & pwdata[`MTS_CTRL_DCLR];
    conf_c = ctrl_wr & pwdata[`MTS_CTRL_CONF];
    ifrst_c = ctrl_wr & pwdata[`MTS_CTRL_IFRST];
    bus_c = ctrl_wr & pwdata[`MTS_CTRL_BUSTRG];
    local_c = ~q.mode[`MTS_MODE_REMOTE];
    ext_fall = q.ext_prev & ~ext_trig_n;
    trig_in = ext_fall | bus_c | q.mode[`MTS_MODE_IMM];
    tick = q.pre == PRE_W'(TICK_CYCLES - 1);
    eff_dly = q.dly_auto ? auto_delay(q.mcfg, local_c & q.mode[`MTS_MODE_FPAUTO]) : q.dly;
    more_trig = local_c | q.trig_inf | (q.trig_done < q.trig_cnt);
    last_samp = (q.samp_done + CNT_W'(1)) >= q.samp_cnt;
    status = '0;
    status[2:0] = q.st;
    status[`MTS_STAT_PEND] = q.pend;
    status[`MTS_STAT_HOLD] = held_valid;
    status[`MTS_STAT_REMOTE] = q.mode[`MTS_MODE_REMOTE];
    status[`MTS_STAT_SAMP_LO +: 16] = q.samp_done[15:0];
  end

  always_comb begin
    d = q;
    d.start = 1'b0;
    d.done_n = 1'b1;
    d.ext_prev = ext_trig_n;
    d.pready = acc;
    d.pslverr = 1'b0;
    d.pre = tick ? '0 : q.pre + PRE_W'(1);
    if (acc) begin
      d.pslverr = 1'b0;
      unique case (paddr)
        `MTS_OFS_CTRL: d.prdata = '0;
        `MTS_OFS_SAMP: d.prdata = 32'(q.samp_cnt);
        `MTS_OFS_TRIG: d.prdata = {q.trig_inf, 31'(q.trig_cnt)};
        `MTS_OFS_DELAY: d.prdata = {q.dly_auto, 31'(q.dly)};
        `MTS_OFS_MCFG: d.prdata = 32'(q.mcfg);
        `MTS_OFS_MODE: d.prdata = 32'(q.mode);
        `MTS_OFS_STATUS: d.prdata = status;
        `MTS_OFS_HELD: d.prdata = 32'(held);
        default: begin
          d.prdata = '0;
          d.pslverr = 1'b1;
        end
      endcase
    end
    if (wr) begin
      unique case (paddr)
        `MTS_OFS_SAMP: d.samp_cnt = clamp_cnt(pwdata);
        `MTS_OFS_TRIG: begin
          d.trig_cnt = clamp_cnt({1'b0, pwdata[30:0]});
          d.trig_inf = pwdata[`MTS_TRIG_INF];
        end
        `MTS_OFS_DELAY: begin
          d.dly_auto = pwdata[`MTS_DELAY_AUTO];
          d.dly = (pwdata[30:0] > 31'(DLY_MAX)) ? DLY_W'(DLY_MAX) : DLY_W'(pwdata[30:0]);
        end
        `MTS_OFS_MCFG: d.mcfg = pwdata[`MTS_MCFG_W-1:0];
        `MTS_OFS_MODE: d.mode = pwdata[`MTS_MODE_W-1:0];
        default: d.mode = d.mode;
      endcase
    end
    if (conf_c | ifrst_c) begin
      d.samp_cnt = CNT_W'(`MTS_CNT_DEF);
      d.trig_cnt = CNT_W'(`MTS_CNT_DEF);
      d.trig_inf = 1'b0;
      d.dly_auto = 1'b1;
    end
    if (ifrst_c) begin
      d.mode[`MTS_MODE_BAND_LO +: 2] = `MTS_BAND_DEF;
    end

    unique case (q.st)
      mtseq_pkg::ST_IDLE: begin
        if (local_c) begin
          d.st = mtseq_pkg::ST_WAIT;
        end else if (arm_c) begin
          d.st = mtseq_pkg::ST_SETUP;
          d.ticks = '0;
          d.pre = '0;
        end
      end
      mtseq_pkg::ST_SETUP: begin
        if (q.ticks >= DLY_W'(SETUP_TICKS)) begin
          d.st = mtseq_pkg::ST_WAIT;
        end else if (tick) begin
          d.ticks = q.ticks + DLY_W'(1);
        end
      end
      mtseq_pkg::ST_WAIT: begin
        if (trig_in | q.pend) begin
          d.pend = 1'b0;
          d.st = mtseq_pkg::ST_DELAY;
          d.trig_done = q.trig_done + CNT_W'(1);
          d.samp_done = '0;
          d.ticks = '0;
          d.pre = '0;
        end
      end
      mtseq_pkg::ST_DELAY: begin
        d.pend = q.pend | ext_fall;
        if (q.ticks >= eff_dly) begin
          d.st = mtseq_pkg::ST_MEAS;
          d.start = 1'b1;
        end else if (tick) begin
          d.ticks = q.ticks + DLY_W'(1);
        end
      end
      mtseq_pkg::ST_MEAS: begin
        d.pend = q.pend | ext_fall;
        if (meas_done) begin
          d.done_n = 1'b0;
          d.samp_done = q.samp_done + CNT_W'(1);
          if (!last_samp) begin
            d.st = mtseq_pkg::ST_DELAY;
            d.ticks = '0;
            d.pre = '0;
          end else if (more_trig) begin
            d.st = mtseq_pkg::ST_WAIT;
          end else begin
            d.st = mtseq_pkg::ST_IDLE;
            d.pend = 1'b0;
            d.trig_done = '0;
          end
        end
      end
    endcase
    if (dclr_c | ifrst_c) begin
      d.st = mtseq_pkg::ST_IDLE;
      d.start = 1'b0;
      d.done_n = 1'b1;
      d.pend = 1'b0;
      d.trig_done = '0;
    end
    d.wait_trig = d.st == mtseq_pkg::ST_WAIT;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= RESET_V;
    end else begin
      q <= d;
    end
  end

  mtseq_hold #(
    .RD_W(RD_W)
  ) u_hold (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .enable(q.mode[`MTS_MODE_HOLD] & local_c),
    .beep_en(q.mode[`MTS_MODE_BEEP]),
    .band(q.mode[`MTS_MODE_BAND_LO +: 2]),
    .reading_valid(reading_valid),
    .reading(reading),
    .held(held),
    .held_valid(held_valid),
    .beep(beep)
  );

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign meas_start = q.start;
  assign measurement_done_output_n = q.done_n;
  assign wait_trig = q.wait_trig;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  no_idle_trig_a: assert property (
    q.st inside {mtseq_pkg::ST_IDLE, mtseq_pkg::ST_SETUP} |=>
    !(q.st inside {mtseq_pkg::ST_DELAY, mtseq_pkg::ST_MEAS}))
    else $error("sequence started without being armed");
  accept_trig_a: assert property (
    q.st == mtseq_pkg::ST_WAIT && ext_fall && !dclr_c && !ifrst_c |=>
    q.st == mtseq_pkg::ST_DELAY ##[1:1000] meas_start)
    else $error("armed trigger did not start a measurement");
  local_arm_a: assert property (
    q.st == mtseq_pkg::ST_IDLE && local_c && !dclr_c && !ifrst_c |=>
    q.st == mtseq_pkg::ST_WAIT)
    else $error("local mode not armed");
  setup_hold_a: assert property (
    q.st == mtseq_pkg::ST_SETUP && q.ticks < DLY_W'(SETUP_TICKS) |=>
    q.st inside {mtseq_pkg::ST_SETUP, mtseq_pkg::ST_IDLE} && !q.pend)
    else $error("setup interval cut short");
  clear_idle_a: assert property (
    dclr_c |=> q.st == mtseq_pkg::ST_IDLE && q.done_n ##1 !meas_start)
    else $error("device clear did not halt");
  clear_keep_a: assert property (
    dclr_c && !conf_c && !ifrst_c |=> $stable(q.samp_cnt) && $stable(q.trig_cnt) &&
    $stable(q.dly) && $stable(q.dly_auto) && $stable(q.mode))
    else $error("device clear changed configuration");
  conf_def_a: assert property (
    conf_c |=> q.samp_cnt == CNT_W'(1) && q.trig_cnt == CNT_W'(1) && q.dly_auto && !q.trig_inf)
    else $error("configure did not restore defaults");
  idle_end_a: assert property (
    q.st == mtseq_pkg::ST_MEAS && meas_done && last_samp && !more_trig |=>
    q.st == mtseq_pkg::ST_IDLE)
    else $error("did not idle after last trigger");
  each_delay_a: assert property (
    q.st == mtseq_pkg::ST_MEAS && meas_done && !last_samp && !dclr_c && !ifrst_c |=>
    q.st == mtseq_pkg::ST_DELAY && q.ticks == '0)
    else $error("no delay before next sample");
  done_pulse_a: assert property (
    q.st == mtseq_pkg::ST_MEAS && meas_done && !dclr_c && !ifrst_c |=>
    !measurement_done_output_n ##1 measurement_done_output_n)
    else $error("done pulse malformed");

  cov_multi_c: cover property (q.st == mtseq_pkg::ST_MEAS && meas_done && !last_samp);
  cov_pend_c: cover property (q.st == mtseq_pkg::ST_WAIT && q.pend);
  cov_clear_c: cover property (q.st == mtseq_pkg::ST_DELAY && dclr_c);

endmodule : mtseq_top
`default_nettype wire

// ### testbench/mtseq_far.sv
// far-side model: measurement path and external trigger source
`timescale 1ns/100ps
`default_nettype none
module mtseq_far #(
  parameter int LAT = 3,
  parameter logic [23:0] VAL = 24'h012345
) (
  input wire logic clk_sys,
  input wire logic meas_start,
  input wire logic trig_req,
  output logic meas_done,
  output logic reading_valid,
  output logic [23:0] reading,
  output logic ext_trig_n
);
  int cnt = 0;
  initial begin
    meas_done = 1'b0;
    reading_valid = 1'b0;
    reading = 24'h0;
    ext_trig_n = 1'b1;
  end
  always @(posedge clk_sys) begin
    meas_done <= (cnt == 1);
    reading_valid <= (cnt == 1);
    // reading bus is only meaningful with its valid
    reading <= (cnt == 1) ? VAL : ~reading;
    if (meas_start === 1'b1) begin
      cnt <= LAT;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
    // low-true trigger pulse, idle high
    ext_trig_n <= ~trig_req;
  end
endmodule : mtseq_far
`default_nettype wire

// ### testbench/mtseq_top_tb_top.sv
// self-checking bench for the trigger sequencer
`timescale 1ns/100ps
`default_nettype none
`include "mtseq_map.svh"
module mtseq_top_tb_top;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic trig_req = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, slv, meas_start, done_n, wait_trig, beep;
  logic meas_done, reading_valid, ext_trig_n;
  logic [23:0] reading;
  int err_total = 0;
  int compares = 0;
  int n_start = 0;
  int n_done = 0;
  int n_beep = 0;
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    n_start += int'(meas_start === 1'b1);
    n_done += int'(done_n === 1'b0);
    n_beep += int'(beep === 1'b1);
  end
  mtseq_top #(.TICK_CYCLES(4), .SETUP_TICKS(3)) uut (
    .clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_trig_n(ext_trig_n),
    .meas_done(meas_done), .reading_valid(reading_valid), .reading(reading),
    .meas_start(meas_start), .measurement_done_output_n(done_n),
    .wait_trig(wait_trig), .beep(beep));
  mtseq_far far (.clk_sys(clk_sys), .meas_start(meas_start), .trig_req(trig_req),
    .meas_done(meas_done), .reading_valid(reading_valid), .reading(reading),
    .ext_trig_n(ext_trig_n));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd);
  endtask : wr
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0, rd);
    chk(rd & m, e);
  endtask : rdm
  task automatic idle(input int c);
    repeat (c) @(posedge clk_sys);
  endtask : idle
  task automatic trig;
    @(posedge clk_sys);
    trig_req <= 1'b1;
    @(posedge clk_sys);
    trig_req <= 1'b0;
  endtask : trig
  task automatic wst(input logic [2:0] e);
    int n;
    n = 0;
    do begin
      apb(1'b0, `MTS_OFS_STATUS, 32'h0, rd);
      n++;
    end while (rd[2:0] !== e && n < 200);
    chk({29'h0, rd[2:0]}, {29'h0, e});
  endtask : wst
  task automatic lat_chk(input int lo);
    int s;
    int n;
    s = n_start;
    n = 0;
    trig;
    while (n_start == s && n < 1000) begin
      @(posedge clk_sys);
      n++;
    end
    chk(32'(n >= lo && n <= lo + 10), 32'h1);
  endtask : lat_chk
  task automatic t_reset;
    rdm(`MTS_OFS_MODE, 32'h3ff, 32'h104);
    rdm(`MTS_OFS_SAMP, 32'hffff, 32'h1);
    rdm(`MTS_OFS_TRIG, 32'h8000ffff, 32'h1);
    rdm(`MTS_OFS_DELAY, 32'h80000000, 32'h80000000);
    apb(1'b0, 8'h40, 32'h0, rd);
    chk({31'h0, slv}, 32'h1);
    wr(`MTS_OFS_SAMP, 32'h0);
    rdm(`MTS_OFS_SAMP, 32'hffff, 32'h1);
    wr(`MTS_OFS_SAMP, 32'hffff);
    rdm(`MTS_OFS_SAMP, 32'hffff, 32'hc350);
    wr(`MTS_OFS_DELAY, 32'h7fffffff);
    rdm(`MTS_OFS_DELAY, 32'h83ffffff, 32'h2255100);
    wr(`MTS_OFS_CTRL, 32'h4);
    $display("test reset done");
  endtask : t_reset
  task automatic t_local;
    int d;
    wr(`MTS_OFS_MODE, 32'h100);
    wst(3'h2);
    for (int i = 0; i < 2; i++) begin
      wr(`MTS_OFS_MCFG, 32'(i) << 8);
      d = n_done;
      lat_chk(40 + 20 * i);
      idle(10);
      chk(32'(n_done - d), 32'h1);
    end
    wr(`MTS_OFS_MCFG, 32'h142);
    lat_chk(600);
    idle(10);
    wr(`MTS_OFS_MODE, 32'h104);
    wr(`MTS_OFS_MCFG, 32'h5);
    lat_chk(0);
    idle(10);
    wr(`MTS_OFS_MCFG, 32'h100);
    wr(`MTS_OFS_MODE, 32'h118);
    d = n_beep;
    repeat (3) begin
      trig;
      idle(90);
    end
    rdm(`MTS_OFS_HELD, 32'hffffff, 32'h012345);
    chk(32'(n_beep - d), 32'h1);
    $display("test local done");
  endtask : t_local
  task automatic t_remote;
    int s;
    wr(`MTS_OFS_MODE, 32'h101);
    wr(`MTS_OFS_CTRL, 32'h2);
    wr(`MTS_OFS_SAMP, 32'h2);
    wr(`MTS_OFS_TRIG, 32'h2);
    wr(`MTS_OFS_DELAY, 32'h2);
    s = n_start;
    wr(`MTS_OFS_CTRL, 32'h1);
    trig;
    wst(3'h2);
    chk({31'h0, wait_trig}, 32'h1);
    chk(32'(n_start - s), 32'h0);
    trig;
    trig;
    wst(3'h0);
    chk({31'h0, wait_trig}, 32'h0);
    chk(32'(n_start - s), 32'h4);
    trig;
    idle(40);
    chk(32'(n_start - s), 32'h4);
    wr(`MTS_OFS_MODE, 32'h103);
    s = n_start;
    wr(`MTS_OFS_CTRL, 32'h1);
    wst(3'h0);
    chk(32'(n_start - s), 32'h4);
    wr(`MTS_OFS_MODE, 32'h101);
    $display("test remote done");
  endtask : t_remote
  task automatic t_clear;
    wr(`MTS_OFS_TRIG, 32'h80000000);
    wr(`MTS_OFS_SAMP, 32'h3);
    wr(`MTS_OFS_DELAY, 32'h5);
    wr(`MTS_OFS_CTRL, 32'h1);
    wst(3'h2);
    trig;
    idle(150);
    rdm(`MTS_OFS_STATUS, 32'h7, 32'h2);
    wr(`MTS_OFS_CTRL, 32'h10);
    idle(3);
    wr(`MTS_OFS_CTRL, 32'h2);
    rdm(`MTS_OFS_STATUS, 32'h7, 32'h0);
    rdm(`MTS_OFS_SAMP, 32'hffff, 32'h3);
    rdm(`MTS_OFS_TRIG, 32'h80000000, 32'h80000000);
    rdm(`MTS_OFS_DELAY, 32'h83ffffff, 32'h5);
    $display("test clear done");
  endtask : t_clear
  task automatic t_conf;
    wr(`MTS_OFS_CTRL, 32'h4);
    rdm(`MTS_OFS_SAMP, 32'hffff, 32'h1);
    rdm(`MTS_OFS_TRIG, 32'h8000ffff, 32'h1);
    rdm(`MTS_OFS_DELAY, 32'h80000000, 32'h80000000);
    wr(`MTS_OFS_MODE, 32'h100);
    repeat (2) begin
      trig;
      idle(90);
    end
    rdm(`MTS_OFS_STATUS, 32'h7, 32'h2);
    rdm(`MTS_OFS_TRIG, 32'hffff, 32'h1);
    wr(`MTS_OFS_MODE, 32'h300);
    wr(`MTS_OFS_CTRL, 32'h8);
    rdm(`MTS_OFS_MODE, 32'h300, 32'h100);
    $display("test configure done");
  endtask : t_conf
  task automatic finish_test;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset;
    t_local;
    t_remote;
    t_clear;
    t_conf;
    finish_test;
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    err_total++;
    finish_test;
  end
endmodule : mtseq_top_tb_top
`default_nettype wire
